// File: hdl/fsp_pkg.sv
// Package with constants, types and register map for the flash status and protect controller.
// Functional notes
// - Status latched on later falling select edge; host toggles select per poll.
// - Fail bits block program or erase; host clears status before retrying.
// - Host masks the two lowest status bits when polling.
// - Protect takes six writes, sixth with lock code and sector address.
// - Sector address latched on falling edge of the sixth write.
// - Unprotect uses five protect writes then the unprotect code.
package fsp_pkg;
   // Controller register byte offsets.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hC;
   // Control register fields.
   localparam int CTRL_GO = 0;
   localparam int CTRL_WR = 1;
   localparam int CTRL_WP = 2;
   localparam int CTRL_PD = 3;
   // Status register fields.
   localparam int ST_BUSY = 0;
   localparam int ST_PDRDY = 1;
   // Device status bit positions.
   localparam int DS_READY = 7;
   localparam int DS_SUSPEND = 6;
   localparam int DS_ERASE_FAIL = 5;
   localparam int DS_PROG_FAIL = 4;
   localparam int DS_PROTECT = 3;
   localparam int DS_SLEEP = 2;
   localparam logic [7:0] DS_POLL_MASK = 8'hFC;
   // Device command codes.
   localparam logic [7:0] CMD_LOCK = 8'h20;
   localparam logic [7:0] CMD_UNLOCK = 8'h40;
   // Pin timing.
   localparam int CLK_MHZ = 50;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   localparam int PULSE_NS = 100;
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVER_NS = 700;
   localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] PULSE_CNT = 6'(PULSE_CYC);
   localparam logic [5:0] RECOVER_CNT = 6'(RECOVER_CYC);
   localparam logic [5:0] CNT_ZERO = 6'h00;
   localparam logic [5:0] CNT_ONE = 6'h01;
   localparam int AW = 20;
   localparam int DW = 16;
   typedef enum logic [2:0]
   {
      FSP_IDLE = 3'b000,
      FSP_SETUP = 3'b001,
      FSP_STROBE = 3'b010,
      FSP_HOLD = 3'b011,
      FSP_DONE = 3'b100
   } fsp_state_e;
endpackage

// File: hdl/fsp_cyc_if.sv
// Interface carrying one pin cycle request from the register block to the pin engine.
`timescale 1ns/1ps
`default_nettype none
interface fsp_cyc_if;
   logic go;
   logic wr;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic done;
   modport ctl (output go, output wr, output addr, output wdata, input rdata, input done);
   modport eng (input go, input wr, input addr, input wdata, output rdata, output done);
endinterface
`default_nettype wire

// File: hdl/fsp_pin_engine.sv
// Pin engine that runs one flash read or write cycle on the parallel pins.
`timescale 1ns/1ps
`default_nettype none
module fsp_pin_engine
   import fsp_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Request.
   fsp_cyc_if.eng cyc,
   // Flash pins.
   output logic chip_sel_n_o,
   output logic out_en_n_o,
   output logic wr_en_n_o,
   output logic [fsp_pkg::AW-1:0] addr_o,
   output logic [fsp_pkg::DW-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [fsp_pkg::DW-1:0] dq_i
);
   import fsp_pkg::*;
   fsp_state_e state;
   fsp_state_e next_state;
   logic [5:0] cnt;
   logic cnt_end;
   assign cnt_end = (cnt == CNT_ZERO);
   always_comb
   begin
      next_state = state;
      case (state)
         FSP_IDLE: if (cyc.go) next_state = FSP_SETUP;
         FSP_SETUP: next_state = FSP_STROBE;
         FSP_STROBE: if (cnt_end) next_state = FSP_HOLD;
         FSP_HOLD: next_state = FSP_DONE;
         FSP_DONE: next_state = FSP_IDLE;
         default: next_state = FSP_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state <= FSP_IDLE;
         cnt <= CNT_ZERO;
         chip_sel_n_o <= 1'b1;
         out_en_n_o <= 1'b1;
         wr_en_n_o <= 1'b1;
         addr_o <= '0;
         dq_o <= '0;
         dq_oe_o <= 1'b0;
         cyc.rdata <= '0;
         cyc.done <= 1'b0;
      end
      else if (ce_i)
      begin
         state <= next_state;
         cyc.done <= (state == FSP_HOLD);
         if (state == FSP_IDLE && cyc.go)
         begin
            addr_o <= cyc.addr;
            dq_o <= cyc.wdata;
            dq_oe_o <= cyc.wr;
         end
         // Select rises after every cycle, so each poll is a fresh edge.
         if (state == FSP_SETUP)
         begin
            cnt <= PULSE_CNT - CNT_ONE;
            chip_sel_n_o <= 1'b0;
            out_en_n_o <= cyc.wr;
            wr_en_n_o <= ~cyc.wr;
         end
         else if (state == FSP_STROBE)
            cnt <= cnt - CNT_ONE;
         if (state == FSP_STROBE && cnt_end)
         begin
            cyc.rdata <= dq_i;
            chip_sel_n_o <= 1'b1;
            out_en_n_o <= 1'b1;
            wr_en_n_o <= 1'b1;
         end
         if (state == FSP_DONE)
            dq_oe_o <= 1'b0;
      end
   end
   chk_sel_pulse_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ce_i && $fell(chip_sel_n_o) |-> ##1 (!chip_sel_n_o) [*4])
      else $error("select pulse shorter than minimum");
   chk_no_oe_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !wr_en_n_o |-> out_en_n_o && dq_oe_o)
      else $error("write strobe with output enable low");
   // The device latches address on the falling strobe, so nothing may move while selected.
   chk_addr_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !chip_sel_n_o |-> $stable(addr_o) && $stable(dq_o))
      else $error("address or data moved while selected");
endmodule // fsp_pin_engine
`default_nettype wire

// File: hdl/fsp_ctrl.sv
// Top of the host controller: Avalon-MM registers driving the flash pin engine.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl
   import fsp_pkg::*;
(
   // Clock, reset and enable.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Flash pins.
   output logic chip_sel_n_o,
   output logic out_en_n_o,
   output logic wr_en_n_o,
   output logic write_protect_n_o,
   output logic power_down_pin_n_o,
   output logic [fsp_pkg::AW-1:0] addr_o,
   output logic [fsp_pkg::DW-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [fsp_pkg::DW-1:0] dq_i
);
   import fsp_pkg::*;
   fsp_cyc_if cyc ();
   logic go;
   logic wr_dir;
   logic wp_high;
   logic pd_req;
   logic busy;
   logic [AW-1:0] addr_reg;
   logic [DW-1:0] wdata_reg;
   logic [DW-1:0] rdata_reg;
   logic [5:0] rec_cnt;
   logic pd_ready;
   logic acc;
   logic acc_done;
   wire sel_ctrl = (avs_address_i == REG_CTRL);
   wire sel_addr = (avs_address_i == REG_ADDR);
   wire sel_data = (avs_address_i == REG_DATA);
   wire sel_stat = (avs_address_i == REG_STAT);
   wire start = avs_write_i && sel_ctrl && avs_writedata_i[CTRL_GO] && !busy && pd_ready;

   wire [7:0] stat_byte = rdata_reg[7:0] & DS_POLL_MASK;
   wire [31:0] rd_mux = sel_ctrl ? {28'h0, pd_req, wp_high, wr_dir, busy} :
                        sel_addr ? {12'h000, addr_reg} :
                        sel_data ? {16'h0000, rdata_reg} :
                        sel_stat ? {16'h0000, stat_byte, 6'h00, pd_ready, busy} : 32'h0;
   assign cyc.go = go;
   assign cyc.wr = wr_dir;
   assign cyc.addr = addr_reg;
   assign cyc.wdata = wdata_reg;

   fsp_pin_engine u_eng (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ce_i(clk_en_i),
      .cyc(cyc),
      .chip_sel_n_o(chip_sel_n_o),
      .out_en_n_o(out_en_n_o),
      .wr_en_n_o(wr_en_n_o),
      .addr_o(addr_o),
      .dq_o(dq_o),
      .dq_oe_o(dq_oe_o),
      .dq_i(dq_i)
   );

   // The answer cycle masks the request for one clock, so a held request is taken again every second clock.
   assign acc = (avs_read_i || avs_write_i) && !acc_done;
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         acc_done <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
      end
      else if (clk_en_i)
      begin
         acc_done <= acc;
         avs_waitrequest_o <= !acc;
         avs_readdata_o <= rd_mux;
      end
   end

   wire take_wr = avs_write_i && acc && clk_en_i;
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         go <= 1'b0;
         busy <= 1'b0;
         wr_dir <= 1'b0;
         wp_high <= 1'b0;
         pd_req <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         rdata_reg <= '0;
         write_protect_n_o <= 1'b0;
         power_down_pin_n_o <= 1'b0;
         rec_cnt <= RECOVER_CNT;
         pd_ready <= 1'b0;
      end
      else if (clk_en_i)
      begin
         go <= 1'b0;
         if (take_wr && sel_addr)
            addr_reg <= avs_writedata_i[AW-1:0];
         if (take_wr && sel_data)
            wdata_reg <= avs_writedata_i[DW-1:0];
         if (take_wr && sel_ctrl)
         begin
            wr_dir <= avs_writedata_i[CTRL_WR];
            wp_high <= avs_writedata_i[CTRL_WP];
            pd_req <= avs_writedata_i[CTRL_PD];
         end
         // Write-protect pin follows software so protect bits can change.
         write_protect_n_o <= wp_high;
         // Power-down pin low aborts device work; no cycle starts then.
         power_down_pin_n_o <= !pd_req;
         if (take_wr && start)
         begin
            go <= 1'b1;
            busy <= 1'b1;
         end
         else if (cyc.done)
         begin
            busy <= 1'b0;
            rdata_reg <= cyc.rdata;
         end
         // Hold off access until recovery time after power-down release.
         if (pd_req)
         begin
            rec_cnt <= RECOVER_CNT;
            pd_ready <= 1'b0;
         end
         else if (rec_cnt != CNT_ZERO)
            rec_cnt <= rec_cnt - CNT_ONE;
         else
            pd_ready <= 1'b1;
      end
   end

   // Counts how long the power-down pin has stood high, saturating at the recovery count.
   // It is kept apart from the recovery counter so the check below does not copy it.
   logic [5:0] pd_high_cnt;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         pd_high_cnt <= CNT_ZERO;
      else if (clk_en_i)
      begin
         if (!power_down_pin_n_o)
            pd_high_cnt <= CNT_ZERO;
         else if (pd_high_cnt != RECOVER_CNT)
            pd_high_cnt <= pd_high_cnt + CNT_ONE;
      end
   end

   chk_recover_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clk_en_i && $fell(pd_req) |-> !pd_ready)
      else $error("access allowed before power-down recovery");

   chk_recover_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pd_ready |-> (pd_high_cnt == RECOVER_CNT))
      else $error("ready before power-down recovery time elapsed");

   chk_stat_mask: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (stat_byte[1:0] == 2'b00))
      else $error("reserved status bits not masked");

   // A cycle may only be launched from an idle, recovered controller.
   chk_go_guard: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(go) |-> $past(pd_ready) && !$past(busy))
      else $error("pin cycle launched while busy or not recovered");

   chk_one_go: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clk_en_i && go |=> !go)
      else $error("launch strobe longer than one cycle");

   chk_busy_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clk_en_i && cyc.done |=> !busy)
      else $error("busy still set after pin cycle ended");

   chk_pd_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clk_en_i && pd_req |=> !power_down_pin_n_o)
      else $error("power-down pin not driven low on request");

endmodule // fsp_ctrl
`default_nettype wire

// File: test/fsp_flash_model.sv
// Behavioural model of the parallel flash device seen at the controller's pins.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model #(
   // Identity values are arbitrary.
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [7:0] DEVICE_ID = 8'hA5
)
(
   // Pins from the controller.
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic wp_i,
   input wire logic pd_n_i,
   input wire logic [19:0] addr_i,
   input wire logic [15:0] dq_i,
   // Data towards the controller.
   output logic [15:0] dq_o
);
   logic [1:0] prot = 2'b00;
   logic [1:0] mode = 2'd0;
   logic [7:0] stat_lat = 8'h80;
   logic [15:0] last = 16'h0000;
   logic [19:0] lat_addr = 20'h0;
   logic rec = 1'b0;
   int wr_cnt = 0;
   // No fail or suspend while idle.
   wire [7:0] status = {1'b1, 3'b000, |prot, 1'b0, 2'b00};
   wire [2:0] sec = lat_addr[19:17];
   wire drv = !ce_n_i && !oe_n_i && we_n_i && pd_n_i && rec;
   wire [15:0] val = (mode == 2'd1) ? {8'h00, stat_lat[7:2], 2'b00} :
      (mode == 2'd2) ? {8'h00, addr_i[0] ? DEVICE_ID : MAKER_ID} : ~addr_i[15:0];
   // A released bus shows the inverse of the last value so stale data cannot pass.
   assign dq_o = drv ? val : ~last;
   always @(negedge drv)
      last = val;
   always @(negedge ce_n_i or negedge oe_n_i)
      if (!ce_n_i && !oe_n_i)
      begin
         stat_lat = status;
         wr_cnt = 0;
      end
   always @(negedge we_n_i)
      lat_addr = addr_i;
   always @(posedge we_n_i)
      if (pd_n_i)
      begin
         case (dq_i[7:0])
            8'h70: mode = 2'd1;
            8'h90: mode = 2'd2;
            8'hFF: mode = 2'd0;
            fsp_pkg::CMD_LOCK, fsp_pkg::CMD_UNLOCK:
            begin
               if (wr_cnt >= 5 && wp_i && (sec == 3'd0 || sec == 3'd7))
                  prot[sec == 3'd7] = (dq_i[7:0] == fsp_pkg::CMD_LOCK);
               mode = 2'd1;
            end
            default: ;
         endcase
         wr_cnt++;
      end
   always @(negedge pd_n_i)
   begin
      mode = 2'd0;
      rec = 1'b0;
   end
   always @(posedge pd_n_i)
      rec <= #700 1'b1;
endmodule // fsp_flash_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the flash status and protect controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fsp_pkg::*;
   // Identity values are arbitrary.
   localparam logic [7:0] MAKER = 8'h3C;
   localparam logic [7:0] DEVID = 8'hC3;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, v;
   logic wreq, cs_n, oe_n, we_n, wp_pin, pd_n, dq_oe;
   logic [19:0] fa;
   logic [15:0] dq_o, dq_m;
   wire [15:0] dq_bus = dq_oe ? dq_o : dq_m;
   logic wp = 1'b0;
   logic pd = 1'b0;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   fsp_ctrl uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .chip_sel_n_o(cs_n),
      .out_en_n_o(oe_n), .wr_en_n_o(we_n), .write_protect_n_o(wp_pin),
      .power_down_pin_n_o(pd_n), .addr_o(fa), .dq_o(dq_o), .dq_oe_o(dq_oe), .dq_i(dq_bus));
   fsp_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID)) mdl (.ce_n_i(cs_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .wp_i(wp_pin), .pd_n_i(pd_n), .addr_i(fa), .dq_i(dq_bus), .dq_o(dq_m));
   initial
      forever #10 ref_clk_i = ~ref_clk_i;
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge ref_clk_i);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      @(posedge ref_clk_i);
      while (wreq !== 1'b0)
         @(posedge ref_clk_i);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // One pin cycle, then the last read data.
   task automatic fl(input logic w, input logic [19:0] a, input logic [15:0] d,
      output logic [31:0] q);
      logic [31:0] s;
      av(1'b1, REG_ADDR, {12'h0, a}, s);
      av(1'b1, REG_DATA, {16'h0, d}, s);
      av(1'b1, REG_CTRL, {28'h0, pd, wp, w, 1'b1}, s);
      s = 32'h1;
      while (s[ST_BUSY] !== 1'b0)
         av(1'b0, REG_STAT, 32'h0, s);
      av(1'b0, REG_DATA, 32'h0, q);
   endtask
   task automatic wait_pd();
      logic [31:0] s;
      s = 32'h0;
      while (s[ST_PDRDY] !== 1'b1)
         av(1'b0, REG_STAT, 32'h0, s);
   endtask
   task automatic seq(input logic [7:0] code, input logic [19:0] a);
      logic [31:0] s;
      repeat (5) fl(1'b1, 20'h0, 16'h00AA, s);
      fl(1'b1, a, {8'h00, code}, s);
   endtask
   initial
   begin
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wait_pd();
      fl(1'b1, 20'h0, 16'h0070, v);
      fl(1'b0, 20'h00010, 16'h0, v);
      cmp("status", 32'h80, v);
      av(1'b0, REG_STAT, 32'h0, v);
      cmp("stat byte", 32'h80, {24'h0, v[15:8]});
      fl(1'b0, 20'h00021, 16'h0, v);
      cmp("status again", 32'h80, v);
      seq(CMD_LOCK, 20'h00000);
      fl(1'b0, 20'h0, 16'h0, v);
      cmp("lock no wp", 32'h80, v);
      wp = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         seq((i < 2 || i == 4) ? CMD_LOCK : CMD_UNLOCK, i[0] ? 20'hE0000 : 20'h00000);
         fl(1'b0, 20'h0, 16'h0, v);
         cmp("protect", (i == 3) ? 32'h80 : 32'h88, v);
      end
      cmp("wp pin", 32'h1, {31'h0, wp_pin});
      fl(1'b1, 20'h0, 16'h0090, v);
      fl(1'b0, 20'h00010, 16'h0, v);
      cmp("maker", {24'h0, MAKER}, v);
      fl(1'b0, 20'h00011, 16'h0, v);
      cmp("device", {24'h0, DEVID}, v);
      fl(1'b1, 20'h0, 16'h00FF, v);
      fl(1'b0, 20'h00123, 16'h0, v);
      cmp("array", 32'hFEDC, v);
      av(1'b0, 4'h2, 32'h0, v);
      cmp("unmapped", 32'h0, v);
      fl(1'b1, 20'h0, 16'h0070, v);
      pd = 1'b1;
      av(1'b1, REG_CTRL, {28'h0, pd, wp, 2'b00}, v);
      av(1'b0, REG_STAT, 32'h0, v);
      cmp("pd pin", 32'h0, {31'h0, pd_n});
      cmp("pd ready", 32'h0, {31'h0, v[ST_PDRDY]});
      pd = 1'b0;
      av(1'b1, REG_CTRL, {28'h0, pd, wp, 2'b00}, v);
      wait_pd();
      fl(1'b0, 20'h00010, 16'h0, v);
      cmp("after pd", 32'hFFEF, v);
      fl(1'b1, 20'h0, 16'h0070, v);
      fl(1'b0, 20'h00010, 16'h0, v);
      cmp("status pd", 32'h88, v);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
